// [hw/tbpsm_port.sv]
// three-bit gpio port with serial-unit pin takeover and ahb-lite register slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`include "tbpsm_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tbpsm_port (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,

  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,

  // standby controls from the power manager
  input  wire logic                  hw_standby,
  input  wire logic                  sw_standby,

  // serial unit control bits
  input  wire logic                  tx_enable_bit,
  input  wire logic                  rx_enable_bit,
  input  wire logic                  external_clock_bit,
  input  wire logic                  internal_clock_out_bit,
  input  wire logic                  sync_mode_bit,

  // serial unit data and clock
  input  wire logic                  serial_tx_data,
  input  wire logic                  serial_clk_out,
  output var  logic                  serial_rx_data,
  output var  logic                  serial_clk_in,
  output var  logic                  serial_unit_reset,

  // two-way port pins
  input  wire tbpsm_pkg::tbpsm_pins_t pin_in,
  output var  tbpsm_pkg::tbpsm_pins_t pin_out,
  output var  tbpsm_pkg::tbpsm_pins_t pin_oe_n
);

  import tbpsm_pkg::*;

  localparam logic [7:0] DIR_RST = `TBPSM_DIR_RST;
  localparam logic [7:0] DAT_RST = `TBPSM_DAT_RST;
  localparam int         TX      = `TBPSM_BIT_TX;
  localparam int         RX      = `TBPSM_BIT_RX;
  localparam int         CK      = `TBPSM_BIT_CLK;

  // address match on a word-aligned byte address of four times the index
  function automatic logic addr_hit(input logic [31:0] a, input logic [15:0] idx);
    addr_hit = (a[31:18] == 14'h0000) && (a[17:2] == idx) && (a[1:0] == 2'h0);
  endfunction : addr_hit

  // gpio role from the direction bit
  function automatic tbpsm_role_e gpio_role(input logic dir);
    gpio_role = dir ? ROLE_GPIO_OUT : ROLE_GPIO_IN;
  endfunction : gpio_role

  // output enable (low = drive) for a role
  function automatic logic role_oe_n(input tbpsm_role_e r);
    role_oe_n = 1'b1;
    unique case (r)
      ROLE_GPIO_IN:  role_oe_n = 1'b1;
      ROLE_GPIO_OUT: role_oe_n = 1'b0;
      ROLE_SER_IN:   role_oe_n = 1'b1;
      ROLE_SER_OUT:  role_oe_n = 1'b0;
    endcase
  endfunction : role_oe_n

  // driven level for a role; inputs park at the latch value
  function automatic logic role_out(input tbpsm_role_e r, input logic gpio_v, input logic ser_v);
    role_out = gpio_v;
    unique case (r)
      ROLE_GPIO_IN:  role_out = gpio_v;
      ROLE_GPIO_OUT: role_out = gpio_v;
      ROLE_SER_IN:   role_out = gpio_v;
      ROLE_SER_OUT:  role_out = ser_v;
    endcase
  endfunction : role_out

  // registers and their next values
  logic [2:0]  ddr_reg;
  logic [2:0]  ddr_next;
  logic [2:0]  dr_reg;
  logic [2:0]  dr_next;
  logic        wr_pend_reg;
  logic        wr_dir_reg;
  logic        wr_dat_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [2:0]  pin_out_reg;
  logic [2:0]  pin_out_next;
  logic [2:0]  pin_oe_n_reg;
  logic [2:0]  pin_oe_n_next;
  logic        ser_rx_reg;
  logic        ser_ck_reg;
  logic        ser_rst_reg;
  logic [2:0]  pin_level;

  // pin levels cross into mclk through four flops
  tbpsm_sync #(
    .W(3)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .d_async (pin_in),
    .q       (pin_level)
  );

  // bus decode
  wire        xfer_ok  = hsel && hready && htrans[1];
  wire        hit_dir  = addr_hit(haddr, `TBPSM_DIR_IDX);
  wire        hit_dat  = addr_hit(haddr, `TBPSM_DAT_IDX);
  wire        rd_fire  = xfer_ok && !hwrite;
  wire        wr_fire  = wr_pend_reg;
  wire        hsize_nc = ^hsize;

  // standby gating; serial unit is held in reset during either standby
  wire        ser_ok   = !sw_standby && !hw_standby;
  wire        tx_own   = tx_enable_bit && ser_ok;
  wire        rx_own   = rx_enable_bit && ser_ok;
  wire        ext_clk_eff = external_clock_bit && ser_ok;
  wire        ckout_eff = !external_clock_bit && (sync_mode_bit || internal_clock_out_bit) && ser_ok;

  // register next values; hardware standby wins over a pending write
  // direction reset value
  assign ddr_next = hw_standby ? DIR_RST[2:0] :
                    (wr_fire && wr_dir_reg) ? hwdata[2:0] : ddr_reg;
  assign dr_next  = hw_standby ? DAT_RST[2:0] :
                    (wr_fire && wr_dat_reg) ? hwdata[2:0] : dr_reg;

  // port read value uses next values so a read right after a write sees it
  // output pins return the latch
  // input pins return the pin level
  wire [2:0] port_val = (ddr_next & dr_next) | (~ddr_next & pin_level);

  // read mux; unmapped addresses read zero
  // direction reads as all ones
  assign hrdata_next = !rd_fire ? hrdata_reg :
                       hit_dir  ? `TBPSM_DIR_READ :
                       hit_dat  ? {24'h000000, `TBPSM_RSVD_ONES, port_val} :
                                  `TBPSM_UNMAPPED_READ;

  // pin roles; no operating-mode input exists, so the mux is mode-free
  // same mux in every mode
  wire tbpsm_role_e ck_role = ext_clk_eff ? ROLE_SER_IN :
                              ckout_eff ? ROLE_SER_OUT : gpio_role(ddr_reg[CK]);
  wire tbpsm_role_e rx_role = rx_own ? ROLE_SER_IN  : gpio_role(ddr_reg[RX]);
  wire tbpsm_role_e tx_role = tx_own ? ROLE_SER_OUT : gpio_role(ddr_reg[TX]);

  // pin drive from roles
  // each pin carries gpio or its serial line
  assign pin_oe_n_next[TX] = role_oe_n(tx_role);
  assign pin_oe_n_next[RX] = role_oe_n(rx_role);
  assign pin_oe_n_next[CK] = role_oe_n(ck_role);
  assign pin_out_next[TX]  = role_out(tx_role, dr_reg[TX], serial_tx_data);
  assign pin_out_next[RX]  = role_out(rx_role, dr_reg[RX], 1'b0);
  assign pin_out_next[CK]  = role_out(ck_role, dr_reg[CK], serial_clk_out);

  // bus address phase capture; zero wait states so hready alone qualifies
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_dir_reg  <= 1'b0;
      wr_dat_reg  <= 1'b0;
    end else begin
      wr_pend_reg <= xfer_ok && hwrite && !hsize_nc | (xfer_ok && hwrite);
      wr_dir_reg  <= hit_dir;
      wr_dat_reg  <= hit_dat;
    end
  end

  // port registers; software standby simply leaves them alone
  // direction held in software standby
  always_ff @(posedge mclk) begin
    if (rst) begin
      ddr_reg <= DIR_RST[2:0];
      dr_reg  <= DAT_RST[2:0];
    end else begin
      ddr_reg <= ddr_next;
      dr_reg  <= dr_next;
    end
  end

  // read data register
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata_reg <= `TBPSM_UNMAPPED_READ;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  // pin and serial-side outputs, all registered
  // serial unit reset in standby
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out_reg  <= 3'h0;
      pin_oe_n_reg <= 3'h7;
      ser_rx_reg   <= 1'b1;
      ser_ck_reg   <= 1'b0;
      ser_rst_reg  <= 1'b1;
    end else begin
      pin_out_reg  <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      ser_rx_reg   <= pin_level[RX];
      ser_ck_reg   <= pin_level[CK];
      ser_rst_reg  <= !ser_ok;
    end
  end

  // outputs straight from flops except the tied-off hreadyout and hresp; response is always okay
  assign hrdata            = hrdata_reg;
  assign hreadyout         = 1'b1;
  assign hresp             = `TBPSM_HRESP_OKAY;
  assign pin_out           = pin_out_reg;
  assign pin_oe_n          = pin_oe_n_reg;
  assign serial_rx_data    = ser_rx_reg;
  assign serial_clk_in     = ser_ck_reg;
  assign serial_unit_reset = ser_rst_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // direction read pattern
  dir_read_ones_a: assert property (rd_fire && hit_dir |=> hrdata == 32'h000000ff)
    else $error("direction read not all ones");

  // hardware standby loads
  // pins are only sure to be released when standby lasted two cycles; enables may return after one
  hws_dir_load_a: assert property (hw_standby |=> ddr_reg == 3'h0 ##1 (pin_oe_n == 3'h7 || !$past(hw_standby)))
    else $error("direction not reset by hardware standby");
  hws_dat_load_a: assert property (hw_standby |=> dr_reg == 3'h0)
    else $error("data not reset by hardware standby");

  // software standby keeps the direction register
  sws_keep_dir_a: assert property (sw_standby && !hw_standby && !wr_fire |=> $stable(ddr_reg))
    else $error("direction lost in software standby");

  // software standby returns pins to gpio and resets the serial unit
  sws_gpio_pins_a: assert property (sw_standby |=> pin_oe_n == ~$past(ddr_reg) && serial_unit_reset)
    else $error("pins not gpio in software standby");

  // reserved bits of a data read
  dat_rsvd_ones_a: assert property (rd_fire && hit_dat |=> hrdata[31:3] == 29'h0000001f)
    else $error("data reserved bits wrong");

  // output pins read the latch, input pins read the level
  read_latch_a: assert property (rd_fire && hit_dat && ddr_next == 3'h7 |=> hrdata[2:0] == $past(dr_next))
    else $error("output pin read not latch");
  read_level_a: assert property (rd_fire && hit_dat && ddr_next == 3'h0 |=> hrdata[2:0] == $past(pin_level))
    else $error("input pin read not level");

  // gpio direction on the tx pin
  gpio_dir_a: assert property (!tx_own |=> pin_oe_n[TX] == !$past(ddr_reg[TX]))
    else $error("gpio drive does not follow direction");

  // clock pin selection
  clk_in_sel_a: assert property (ext_clk_eff |=> pin_oe_n[CK])
    else $error("clock pin drives while external");
  clk_out_sel_a: assert property (ckout_eff |=> !pin_oe_n[CK] && pin_out[CK] == $past(serial_clk_out))
    else $error("clock pin not serial output");

  // tx and rx pin selection
  tx_drive_a: assert property (tx_own |=> !pin_oe_n[TX] && pin_out[TX] == $past(serial_tx_data))
    else $error("tx pin not serial output");
  rx_input_a: assert property (rx_own |=> pin_oe_n[RX])
    else $error("rx pin drives while receiving");

  // main scenarios
  tx_use_c:    cover property (tx_own ##1 !pin_oe_n[TX]);
  clk_out_c:   cover property (ckout_eff ##1 !pin_oe_n[CK]);
  sws_entry_c: cover property (tx_own ##1 sw_standby ##1 serial_unit_reset);
  dir_read_c:  cover property (rd_fire && hit_dir);

endmodule : tbpsm_port

`default_nettype wire

// [hw/tbpsm_map.svh]
// register indices, reset values, pin positions and bus codes of the three-bit port
`ifndef TBPSM_MAP_SVH
`define TBPSM_MAP_SVH

// register indices; byte address is four times the index
`define TBPSM_DIR_IDX       16'hffb8
`define TBPSM_DAT_IDX       16'hffba

// reset values of the full 8-bit registers
`define TBPSM_DIR_RST       8'hf8
`define TBPSM_DAT_RST       8'hf8

// fixed read patterns
`define TBPSM_RSVD_ONES     5'h1f
`define TBPSM_DIR_READ      32'h000000ff
`define TBPSM_UNMAPPED_READ 32'h00000000

// pin positions inside the port
`define TBPSM_BIT_TX        0
`define TBPSM_BIT_RX        1
`define TBPSM_BIT_CLK       2

// ahb-lite codes
`define TBPSM_HRESP_OKAY    1'h0

`endif

// [hw/tbpsm_pkg.sv]
// types shared by the three-bit port with serial multiplexing
`default_nettype none

package tbpsm_pkg;

  // one bit per port pin
  typedef logic [2:0] tbpsm_pins_t;

  // what a pin is doing this cycle
  typedef enum logic [3:0] {
    ROLE_GPIO_IN  = 4'b0001,
    ROLE_GPIO_OUT = 4'b0010,
    ROLE_SER_IN   = 4'b0100,
    ROLE_SER_OUT  = 4'b1000
  } tbpsm_role_e;

endpackage : tbpsm_pkg

`default_nettype wire

// [hw/tbpsm_sync.sv]
// three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/1ps
`default_nettype none

module tbpsm_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // asynchronous levels and filtered result
  input  wire logic [W-1:0] d_async,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // a bit changes only once stages two and three agree
  assign q_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q);

  // s1 feeds s2 only; nothing else looks at it
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= q_next;
    end
  end

endmodule : tbpsm_sync

`default_nettype wire

// [tb/tbpsm_pin_model.sv]
// far side of the port: the pin wires, an outside part and the serial unit
`timescale 1ns/1ps
`default_nettype none

module tbpsm_pin_model (
  // clock
  input  wire logic                   mclk,
  // device side of the pins
  input  wire tbpsm_pkg::tbpsm_pins_t pin_out,
  input  wire tbpsm_pkg::tbpsm_pins_t pin_oe_n,
  output var  tbpsm_pkg::tbpsm_pins_t pin_in,
  // level the outside part puts on a released pin
  input  wire tbpsm_pkg::tbpsm_pins_t ext_level,
  // serial unit
  input  wire logic                   serial_unit_reset,
  output var  logic                   serial_tx_data,
  output var  logic                   serial_clk_out
);
  import tbpsm_pkg::*;

  // wire level: the device wins where it drives, else the outside part
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);

  // tx and clock toggle every cycle so a stale copy never matches
  // serial unit reset
  always_ff @(posedge mclk) begin
    if (serial_unit_reset) begin
      serial_tx_data <= 1'b1;
      serial_clk_out <= 1'b1;
    end else begin
      serial_tx_data <= ~serial_tx_data;
      serial_clk_out <= ~serial_clk_out;
    end
  end
endmodule : tbpsm_pin_model

`default_nettype wire

// [tb/test_three_bit_port_with_serial_mux.sv]
// self-checking bench of the three-bit port with serial pin takeover
`include "tbpsm_map.svh"
`timescale 1ns/1ps
`default_nettype none

module test_three_bit_port_with_serial_mux;
  import tbpsm_pkg::*;
  localparam logic [31:0] a_dir = {14'h0, `TBPSM_DIR_IDX, 2'b00};
  localparam logic [31:0] a_dat = {14'h0, `TBPSM_DAT_IDX, 2'b00};

  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        hw_standby = 1'b0;
  logic        sw_standby = 1'b0;
  logic        tx_enable_bit = 1'b0;
  logic        rx_enable_bit = 1'b0;
  logic        external_clock_bit = 1'b0;
  logic        internal_clock_out_bit = 1'b0;
  logic        sync_mode_bit = 1'b0;
  logic        serial_tx_data;
  logic        serial_clk_out;
  logic        serial_rx_data;
  logic        serial_clk_in;
  logic        serial_unit_reset;
  tbpsm_pins_t pin_in;
  tbpsm_pins_t pin_out;
  tbpsm_pins_t pin_oe_n;
  tbpsm_pins_t ext_level = 3'h0;
  int          checks = 0;
  int          n_mismatch = 0;
  // external, sync, clock-out bits; external first to show it wins
  logic [2:0]  clk_modes [5] = '{3'h4, 3'h6, 3'h2, 3'h1, 3'h0};

  tbpsm_port tbpsm_port_inst (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .tx_enable_bit(tx_enable_bit), .rx_enable_bit(rx_enable_bit),
    .external_clock_bit(external_clock_bit), .internal_clock_out_bit(internal_clock_out_bit),
    .sync_mode_bit(sync_mode_bit), .serial_tx_data(serial_tx_data),
    .serial_clk_out(serial_clk_out), .serial_rx_data(serial_rx_data),
    .serial_clk_in(serial_clk_in), .serial_unit_reset(serial_unit_reset),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

  tbpsm_pin_model tbpsm_pin_model_inst (
    .mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
    .ext_level(ext_level), .serial_unit_reset(serial_unit_reset),
    .serial_tx_data(serial_tx_data), .serial_clk_out(serial_clk_out));

  // 20 MHz clock
  always #25 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // single word transfer; each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // data word as read: reserved bits high above the port bits
  function automatic logic [31:0] pw(input logic [2:0] p);
    return {24'h0, `TBPSM_RSVD_ONES, p};
  endfunction : pw

  task automatic wrap_up;
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    tick(3);
    rst <= 1'b0;
    tick(6);
    rdchk(a_dir, `TBPSM_DIR_READ);
    rdchk(a_dat, pw(3'h0));
    chk(pin_oe_n, 3'h7);
    chk(hresp, `TBPSM_HRESP_OKAY);
    chk(hreadyout, 1'b1);
    // read right after write still sees the latch, pins still at the old level
    ext_level <= 3'h2;
    xfer(1'b1, a_dir, 32'h7);
    xfer(1'b1, a_dat, 32'h5);
    rdchk(a_dat, pw(3'h5));
    tick(2);
    chk(pin_oe_n, 3'h0);
    chk(pin_out, 3'h5);
    xfer(1'b1, a_dir, 32'h0);
    xfer(1'b1, a_dat, 32'hfffffffa);
    ext_level <= 3'h5;
    tick(6);
    chk(pin_oe_n, 3'h7);
    rdchk(a_dat, pw(3'h5));
    xfer(1'b1, a_dir, 32'h7);
    rdchk(a_dat, pw(3'h2));
    rdchk(a_dat + 32'h4, `TBPSM_UNMAPPED_READ);
    // every clock-pin mode with direction set and data bit low
    foreach (clk_modes[i]) begin
      {external_clock_bit, sync_mode_bit, internal_clock_out_bit} <= clk_modes[i];
      tick(8);
      chk(pin_oe_n[2], clk_modes[i][2]);
      if (clk_modes[i][2])
        chk(serial_clk_in, 1'b1);
      else
        chk(pin_out[2], (clk_modes[i] == 3'h0) ? 1'b0 : !serial_clk_out);
    end
    {tx_enable_bit, rx_enable_bit} <= 2'h3;
    tick(8);
    chk(pin_oe_n, 3'h2);
    repeat (3) begin
      tick(1);
      chk(pin_out[0], !serial_tx_data);
    end
    chk(serial_rx_data, 1'b0);
    rdchk(a_dat, pw(3'h2));
    tx_enable_bit <= 1'b0;
    xfer(1'b1, a_dir, 32'h0);
    tick(8);
    rdchk(a_dat, pw(3'h5));
    // software standby while the serial unit owns the tx pin
    rx_enable_bit <= 1'b0;
    xfer(1'b1, a_dir, 32'h1);
    xfer(1'b1, a_dat, 32'h0);
    tx_enable_bit <= 1'b1;
    tick(3);
    chk(serial_unit_reset, 1'b0);
    sw_standby <= 1'b1;
    tick(3);
    chk(serial_unit_reset, 1'b1);
    chk(pin_oe_n, 3'h6);
    chk(pin_out[0], 1'b0);
    sw_standby <= 1'b0;
    tx_enable_bit <= 1'b0;
    tick(3);
    rdchk(a_dat, pw(3'h4));
    // hardware standby clears both registers
    xfer(1'b1, a_dat, 32'h7);
    hw_standby <= 1'b1;
    tick(3);
    chk(pin_oe_n, 3'h7);
    hw_standby <= 1'b0;
    xfer(1'b1, a_dir, 32'h7);
    rdchk(a_dat, pw(3'h0));
    wrap_up;
  end

  // watchdog, well beyond the under 150 cycles the sequence needs
  initial begin
    tick(3000);
    n_mismatch++;
    wrap_up;
  end
endmodule : test_three_bit_port_with_serial_mux

`default_nettype wire
